// ---- shared/rsq_regs.vh ----
`ifndef RSQ_REGS_VH
`define RSQ_REGS_VH
// ----------------------------------------
// Modes
// ----------------------------------------
`define RSQ_MODE_INIT    2'h0
`define RSQ_MODE_NORMAL  2'h1
`define RSQ_MODE_STOP    2'h2
`define RSQ_MODE_SOFT    2'h3
// ----------------------------------------
// Defaults and timing
// ----------------------------------------
`define RSQ_THR_DEFAULT  2'h0
`define RSQ_CLK_MHZ      100
`define RSQ_TRF_US       10
`define RSQ_RESET_DELAY_SHORT_US      10000
`define RSQ_RESET_DELAY_LONG_US      2000
`define RSQ_TCFG_US      10
`define RSQ_CNT_W        24
`define RSQ_ZERO_CNT     24'h000000
`define RSQ_ONE_CNT      24'h000001
`endif

// ---- verification/rsq_asserts.sv ----
`default_nettype none
// ----
// Checker
// ----
module rsq_asserts #(
    parameter int TRF_CYC  = 4,
    parameter int RESET_DELAY_LONG_CYC = 10
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       ce_i,
    input wire logic       rail_uv_i,
    input wire logic       rail_ok_rise_i,
    input wire logic       wd_fail_i,
    input wire logic       wr_i,
    input wire logic [1:0] wr_mode_i,
    input wire logic [1:0] mode_o,
    input wire logic       soft_reset_output_select_o,
    input wire logic [1:0] uv_threshold_sel_o,
    input wire logic       crc_pullup_en_o,
    input wire logic       soft_reset_pulse_o,
    input wire logic       reset_output_active_low_o
);
    int   uv_cnt;
    int   ok_cnt;
    logic soft_req;
    logic acc;
    assign soft_req = ce_i && wr_i && wr_mode_i == 2'h3;
    assign acc = soft_req && (mode_o == 2'h1 || mode_o == 2'h2);
    // Event-free run length, the release delay can only start inside it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uv_cnt <= 0;
            ok_cnt <= 0;
        end else begin
            uv_cnt <= rail_uv_i ? uv_cnt + 1 : 0;
            ok_cnt <= (rail_ok_rise_i && !rail_uv_i && !wd_fail_i && !soft_req) ? ok_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_soft_accept: assert property (acc |=> soft_reset_pulse_o && mode_o == 2'h0)
        else $error("soft reset not taken");
    a_soft_ignore: assert property (soft_req && mode_o == 2'h0 |=> !soft_reset_pulse_o
        && $stable(uv_threshold_sel_o)) else $error("soft reset taken in init");
    a_soft_defaults: assert property (soft_reset_pulse_o |-> uv_threshold_sel_o == 2'h0
        && !soft_reset_output_select_o) else $error("defaults not restored");
    a_soft_out: assert property (acc && !soft_reset_output_select_o |-> ##2
        !reset_output_active_low_o) else $error("soft reset left output high");
    a_soft_quiet: assert property (acc && soft_reset_output_select_o && reset_output_active_low_o
        |-> ##1 reset_output_active_low_o [*3]) else $error("output pulsed");
    a_uv_filter: assert property (rail_uv_i && uv_cnt <= TRF_CYC && reset_output_active_low_o
        |=> reset_output_active_low_o) else $error("unfiltered reset");
    a_uv_hold: assert property (rail_uv_i && uv_cnt > TRF_CYC + 4
        |-> !reset_output_active_low_o) else $error("released during event");
    a_release_gap: assert property ($rose(reset_output_active_low_o) |-> ok_cnt > RESET_DELAY_LONG_CYC)
        else $error("release delay too short");
    a_por_low: assert property ($rose(rst_n_i) |-> !reset_output_active_low_o)
        else $error("output high at power on");
    a_pullup_off: assert property (!crc_pullup_en_o |=> !crc_pullup_en_o)
        else $error("pull-up back on");
    c_soft: cover property (acc);
    c_uv: cover property (rail_uv_i && uv_cnt > TRF_CYC + 4);
    c_release: cover property ($rose(reset_output_active_low_o));
endmodule // rsq_asserts
bind rsq_reset_seq rsq_asserts #(.TRF_CYC(TRF_CYC), .RESET_DELAY_LONG_CYC(RESET_DELAY_LONG_CYC)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .rail_uv_i(rail_uv_i),
    .rail_ok_rise_i(rail_ok_rise_i), .wd_fail_i(wd_fail_i), .wr_i(wr_i),
    .wr_mode_i(wr_mode_i), .mode_o(mode_o), .uv_threshold_sel_o(uv_threshold_sel_o),
    .soft_reset_output_select_o(soft_reset_output_select_o), .crc_pullup_en_o(crc_pullup_en_o),
    .soft_reset_pulse_o(soft_reset_pulse_o), .reset_output_active_low_o(reset_output_active_low_o));
`default_nettype wire

// ---- verification/rsq_host_model.sv ----
`default_nettype none
// ----
// Host side: counts resets seen
// ----
module rsq_host_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic reset_n_i,
    input  wire logic soft_pulse_i,
    output var  int   soft_cnt_o,
    output var  int   rst_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_cnt_o <= 0;
            rst_cnt_o <= 0;
            last_r <= 1'b0;
        end else begin
            // CRC state must be read again after each of these
            soft_cnt_o <= soft_cnt_o + (soft_pulse_i ? 1 : 0);
            rst_cnt_o <= rst_cnt_o + ((last_r && !reset_n_i) ? 1 : 0);
            last_r <= reset_n_i;
        end
    end
endmodule // rsq_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RESET_FILTER_TIME = 4;
    localparam int RESET_DELAY_SHORT = 20;
    localparam int RESET_DELAY_LONG = 10;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       ce_i = 1'b1;
    logic       uv_i = 1'b0;
    logic       ok_i = 1'b0;
    logic       wd_i = 1'b0;
    logic       wr_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic       dsel_i = 1'b0;
    logic       sro_i = 1'b0;
    logic [1:0] thr_i = 2'h0;
    wire  [1:0] mode_o, thr_o;
    wire        dsel_o, sro_o, crc_o, pu_o, pulse_o, rst_o;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         soft_cnt, rst_cnt, n;
    always #5 clk_i = ~clk_i;
    rsq_reset_seq #(.TRF_CYC(24'h000004), .RESET_DELAY_SHORT_CYC(24'h000014), .RESET_DELAY_LONG_CYC(24'h00000a),
        .TCFG_CYC(24'h000004)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .rail_uv_i(uv_i), .rail_ok_rise_i(ok_i), .crc_select_config_pin_i(1'b1),
        .wd_fail_i(wd_i), .wr_i(wr_i), .wr_mode_i(mode_i), .wr_delay_sel_i(dsel_i),
        .wr_sro_sel_i(sro_i), .wr_thr_i(thr_i), .mode_o(mode_o), .reset_delay_select_o(dsel_o),
        .soft_reset_output_select_o(sro_o), .uv_threshold_sel_o(thr_o), .crc_enable_o(crc_o),
        .crc_pullup_en_o(pu_o), .soft_reset_pulse_o(pulse_o), .reset_output_active_low_o(rst_o));
    rsq_host_model host_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_n_i(rst_o),
        .soft_pulse_i(pulse_o), .soft_cnt_o(soft_cnt), .rst_cnt_o(rst_cnt));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] m, input logic d, input logic s, input logic [1:0] t);
        wr_i = 1'b1;
        mode_i = m;
        dsel_i = d;
        sro_i = s;
        thr_i = t;
        @(negedge clk_i);
        wr_i = 1'b0;
        // Idle cycle so a following call never re-raises the strobe in the same step
        @(negedge clk_i);
    endtask
    task automatic wait_lvl(input logic lvl);
        n = 0;
        while (rst_o !== lvl && n < 100) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (30) @(negedge clk_i);
        chk("rst_hold", rst_o, 0);
        chk("thr_default", thr_o, 0);
        ok_i = 1'b1;
        wait_lvl(1'b1);
        chk("por_release", n >= RESET_DELAY_SHORT && n <= RESET_DELAY_SHORT + 6, 1);
        chk("crc_latched", crc_o, 1);
        chk("pullup_off", pu_o, 0);
        wr(2'h0, 1'b0, 1'b0, 2'h1);
        wr(2'h3, 1'b1, 1'b1, 2'h3);
        chk("init_ignore", thr_o, 1);
        wr(2'h1, 1'b0, 1'b0, 2'h2);
        chk("thr_set", thr_o, 2);
        wr(2'h3, 1'b1, 1'b1, 2'h0);
        chk("soft_mode", mode_o, 0);
        chk("soft_thr", thr_o, 0);
        wait_lvl(1'b0);
        chk("soft_low", rst_o, 0);
        chk("soft_seen", soft_cnt[7:0], 1);
        wait_lvl(1'b1);
        chk("soft_release", n >= RESET_DELAY_SHORT && n <= RESET_DELAY_SHORT + 4, 1);
        wr(2'h2, 1'b0, 1'b1, 2'h0);
        wr(2'h3, 1'b0, 1'b0, 2'h0);
        repeat (8) @(negedge clk_i);
        chk("quiet_falls", rst_cnt[7:0], 1);
        chk("quiet_soft", soft_cnt[7:0], 2);
        chk("quiet_mode", mode_o, 0);
        wd_i = 1'b1;
        @(negedge clk_i);
        wd_i = 1'b0;
        wait_lvl(1'b0);
        chk("wd_low", n <= 6, 1);
        wait_lvl(1'b1);
        chk("wd_release", n >= RESET_DELAY_SHORT && n <= RESET_DELAY_SHORT + 4, 1);
        wr(2'h1, 1'b1, 1'b0, 2'h0);
        uv_i = 1'b1;
        repeat (2) @(negedge clk_i);
        uv_i = 1'b0;
        repeat (10) @(negedge clk_i);
        chk("uv_glitch", rst_o, 1);
        uv_i = 1'b1;
        repeat (30) @(negedge clk_i);
        chk("uv_low", rst_o, 0);
        uv_i = 1'b0;
        wait_lvl(1'b1);
        chk("uv_release", n >= RESET_FILTER_TIME + RESET_DELAY_LONG && n <= RESET_FILTER_TIME + RESET_DELAY_LONG + 6, 1);
        // Enable low must freeze the sequencer against a watchdog failure
        ce_i = 1'b0;
        wd_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("ce_freeze", rst_o, 1);
        wd_i = 1'b0;
        ce_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("ce_resume", rst_o, 1);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire

// ---- verilog/rsq_filter.v ----
`include "rsq_regs.vh"
`default_nettype none
// ----------------------------------------
// Persistence filter: output follows input after it held steady
// ----------------------------------------
module rsq_filter #(
    parameter [`RSQ_CNT_W-1:0] LEN = `RSQ_ONE_CNT
) (
    // Clock, reset, enable
    input  wire                  clk_i,
    input  wire                  rst_n_i,
    input  wire                  en_i,
    // Data
    input  wire                  d_i,
    output reg                   q_o
);
    reg [`RSQ_CNT_W-1:0] cnt_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= `RSQ_ZERO_CNT;
            q_o   <= 1'b0;
        end else if (en_i) begin
            if (d_i == q_o) begin
                cnt_r <= `RSQ_ZERO_CNT;
            end else if (cnt_r >= LEN - `RSQ_ONE_CNT) begin
                cnt_r <= `RSQ_ZERO_CNT;
                q_o   <= d_i;
            end else begin
                cnt_r <= cnt_r + `RSQ_ONE_CNT;
            end
        end
    end
endmodule // rsq_filter
`default_nettype wire

// ---- verilog/rsq_reset_seq.v ----
`include "rsq_regs.vh"
`default_nettype none
module rsq_reset_seq #(
    parameter [`RSQ_CNT_W-1:0] TRF_CYC  = `RSQ_TRF_US * `RSQ_CLK_MHZ,
    parameter [`RSQ_CNT_W-1:0] RESET_DELAY_SHORT_CYC = `RSQ_RESET_DELAY_SHORT_US * `RSQ_CLK_MHZ,
    parameter [`RSQ_CNT_W-1:0] RESET_DELAY_LONG_CYC = `RSQ_RESET_DELAY_LONG_US * `RSQ_CLK_MHZ,
    parameter [`RSQ_CNT_W-1:0] TCFG_CYC = `RSQ_TCFG_US * `RSQ_CLK_MHZ
) (
    // Clock, reset, enable
    input  wire                  clk_i,
    input  wire                  rst_n_i,
    input  wire                  ce_i,
    // Supervision pins (asynchronous)
    input  wire                  rail_uv_i,
    input  wire                  rail_ok_rise_i,
    input  wire                  crc_select_config_pin_i,
    // Same-domain events
    input  wire                  wd_fail_i,
    // Register write port
    input  wire                  wr_i,
    input  wire [1:0]            wr_mode_i,
    input  wire                  wr_delay_sel_i,
    input  wire                  wr_sro_sel_i,
    input  wire [1:0]            wr_thr_i,
    // Register state
    output reg  [1:0]            mode_o,
    output reg                   reset_delay_select_o,
    output reg                   soft_reset_output_select_o,
    output reg  [1:0]            uv_threshold_sel_o,
    output reg                   crc_enable_o,
    output reg                   crc_pullup_en_o,
    output reg                   soft_reset_pulse_o,
    // Reset pin
    output reg                   reset_output_active_low_o
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    reg [1:0] uv_s_r;
    reg [1:0] ok_s_r;
    reg [1:0] crc_s_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uv_s_r  <= 2'h0;
            ok_s_r  <= 2'h0;
            crc_s_r <= 2'h0;
        end else if (ce_i) begin
            uv_s_r  <= {uv_s_r[0], rail_uv_i};
            ok_s_r  <= {ok_s_r[0], rail_ok_rise_i};
            crc_s_r <= {crc_s_r[0], crc_select_config_pin_i};
        end
    end
    wire uv_sync  = uv_s_r[1];
    wire ok_sync  = ok_s_r[1];
    wire crc_sync = crc_s_r[1];

    // ----------------------------------------
    // Undervoltage filter
    // ----------------------------------------
    wire uv_filt;
    rsq_filter #(
        .LEN     (TRF_CYC)
    ) u_uv_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (ce_i),
        .d_i     (uv_sync),
        .q_o     (uv_filt)
    );

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    localparam [3:0] ST_POWERUP = 4'h1;
    localparam [3:0] ST_RUN     = 4'h2;
    localparam [3:0] ST_HOLD    = 4'h4;
    localparam [3:0] ST_DELAY   = 4'h8;

    reg [3:0]            st_r;
    reg [3:0]            st_nxt;
    reg [`RSQ_CNT_W-1:0] dly_r;
    reg [`RSQ_CNT_W-1:0] dly_nxt;
    reg                  long_r;
    reg                  long_nxt;
    reg                  wd_hit_r;
    reg                  soft_hit_r;
    reg                  pwrup_r;
    reg                  pwrup_nxt;

    // Accepted soft reset only from Normal or Stop
    wire soft_req = wr_i && (wr_mode_i == `RSQ_MODE_SOFT) &&
                    ((mode_o == `RSQ_MODE_NORMAL) ||
                     (mode_o == `RSQ_MODE_STOP));
    wire soft_drive = soft_req && !soft_reset_output_select_o;

    function [`RSQ_CNT_W-1:0] delay_len;
        input sel_long;
        begin
            delay_len = sel_long ? RESET_DELAY_LONG_CYC : RESET_DELAY_SHORT_CYC;
        end
    endfunction

    // Watchdog and soft reset bypass the filter: they are already clean events
    wire event_now = uv_filt || wd_hit_r || soft_hit_r;

    always @* begin
        st_nxt    = st_r;
        dly_nxt   = dly_r;
        long_nxt  = long_r;
        pwrup_nxt = pwrup_r;
        case (st_r)
            ST_POWERUP: begin
                if (ok_sync) begin
                    st_nxt   = ST_DELAY;
                    long_nxt = 1'b0;
                    dly_nxt  = `RSQ_ZERO_CNT;
                end
            end
            ST_RUN: begin
                if (event_now) begin
                    st_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!uv_filt) begin
                    st_nxt   = ST_DELAY;
                    long_nxt = reset_delay_select_o;
                    dly_nxt  = `RSQ_ZERO_CNT;
                end
            end
            ST_DELAY: begin
                if (uv_filt) begin
                    st_nxt = ST_HOLD;
                end else if (dly_r >= delay_len(long_r) - `RSQ_ONE_CNT) begin
                    st_nxt    = ST_RUN;
                    pwrup_nxt = 1'b0;
                end else begin
                    dly_nxt = dly_r + `RSQ_ONE_CNT;
                end
            end
            default: begin
                st_nxt = ST_POWERUP;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r       <= ST_POWERUP;
            dly_r      <= `RSQ_ZERO_CNT;
            long_r     <= 1'b0;
            pwrup_r    <= 1'b1;
            wd_hit_r   <= 1'b0;
            soft_hit_r <= 1'b0;
            reset_output_active_low_o <= 1'b0;
        end else if (ce_i) begin
            st_r       <= st_nxt;
            dly_r      <= dly_nxt;
            long_r     <= long_nxt;
            pwrup_r    <= pwrup_nxt;
            wd_hit_r   <= wd_fail_i;
            soft_hit_r <= soft_drive;
            reset_output_active_low_o <= (st_nxt == ST_RUN);
        end
    end

    // ----------------------------------------
    // Control bits and soft reset
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_o                     <= `RSQ_MODE_INIT;
            reset_delay_select_o       <= 1'b0;
            soft_reset_output_select_o <= 1'b0;
            uv_threshold_sel_o         <= `RSQ_THR_DEFAULT;
            soft_reset_pulse_o         <= 1'b0;
        end else if (ce_i) begin
            soft_reset_pulse_o <= soft_req;
            if (soft_req) begin
                mode_o                     <= `RSQ_MODE_INIT;
                reset_delay_select_o       <= 1'b0;
                soft_reset_output_select_o <= 1'b0;
                uv_threshold_sel_o         <= `RSQ_THR_DEFAULT;
            end else if (st_r == ST_HOLD) begin
                mode_o <= `RSQ_MODE_INIT;
            end else if (wr_i && (wr_mode_i != `RSQ_MODE_SOFT)) begin
                mode_o                     <= wr_mode_i;
                reset_delay_select_o       <= wr_delay_sel_i;
                soft_reset_output_select_o <= wr_sro_sel_i;
                uv_threshold_sel_o         <= wr_thr_i;
            end
        end
    end

    // ----------------------------------------
    // CRC select start-up check
    // ----------------------------------------
    // Filter restarts on any glitch; choice latched once only
    reg [`RSQ_CNT_W-1:0] cfg_cnt_r;
    reg                  cfg_last_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_cnt_r       <= `RSQ_ZERO_CNT;
            cfg_last_r      <= 1'b0;
            crc_enable_o    <= 1'b0;
            crc_pullup_en_o <= 1'b1;
        end else if (ce_i && crc_pullup_en_o) begin
            cfg_last_r <= crc_sync;
            if (crc_sync != cfg_last_r) begin
                cfg_cnt_r <= `RSQ_ZERO_CNT;
            end else if (cfg_cnt_r >= TCFG_CYC - `RSQ_ONE_CNT) begin
                crc_enable_o    <= crc_sync;
                crc_pullup_en_o <= 1'b0;
            end else begin
                cfg_cnt_r <= cfg_cnt_r + `RSQ_ONE_CNT;
            end
        end
    end
endmodule // rsq_reset_seq
`default_nettype wire
